// [pkg/wdt_pkg.sv]
// constants and types shared by the watchdog and interval timer
package wdt_pkg;
	localparam logic [7:0] PW_COUNT         = 8'h5A;
	localparam logic [7:0] PW_CTRL          = 8'hA5;
	localparam int         OVF_BIT          = 7;
	localparam int         MODE_BIT         = 6;
	localparam int         RUN_BIT          = 5;
	localparam int         RSV_BIT          = 4;
	localparam int         ACT_BIT          = 3;
	localparam int         CKS_LSB          = 0;
	localparam int         CKS_W            = 3;
	localparam logic [7:0] CTRL_RESET       = 8'h10;
	localparam logic [7:0] COUNT_RESET      = 8'h00;
	localparam logic [7:0] COUNT_TOP        = 8'hFF;
	localparam int         RST_PULSE_CYCLES = 518;
	localparam int         RST_CNT_W        = 10;
	localparam int         PRESC_W          = 12;
	localparam int         DIV_SHIFT_W      = 4;

	typedef enum logic {ST_RUN, ST_WDT_RESET} wdt_state_t;

	// log2 of the count clock divisor: /2 /32 /64 /128 /256 /512 /2048 /4096
	function automatic logic [DIV_SHIFT_W-1:0] div_shift(input logic [CKS_W-1:0] sel);
		logic [DIV_SHIFT_W-1:0] s;
		s = 4'h1;
		case (sel)
			3'h0:    s = 4'h1;
			3'h1:    s = 4'h5;
			3'h2:    s = 4'h6;
			3'h3:    s = 4'h7;
			3'h4:    s = 4'h8;
			3'h5:    s = 4'h9;
			3'h6:    s = 4'hB;
			3'h7:    s = 4'hC;
			default: s = 4'h1;
		endcase
		return s;
	endfunction
endpackage

// [rtl/wdt_prescaler.sv]
// system clock prescaler that produces the selectable count clock pulse
`timescale 1ns/1ps
module wdt_prescaler #(
	parameter int PRESC_W = 12
) (
	input  wire logic                       mclk,
	input  wire logic                       sys_rst,
	input  wire logic                       clr,
	input  wire logic [wdt_pkg::CKS_W-1:0]  clk_sel,
	output logic                            tick
);
	if (PRESC_W < 12)
	begin : g_bad_width
		$error("prescaler needs at least 12 bits for the /4096 tap");
	end

	logic [PRESC_W-1:0] div_q;
	logic [PRESC_W-1:0] div_d;
	logic [PRESC_W-1:0] mask;
	logic               tick_d;
	logic               tick_q;

	always_comb
	begin
		mask   = (PRESC_W'(1) << wdt_pkg::div_shift(clk_sel)) - PRESC_W'(1);
		// held in step with the run bit so the first interval is a full one
		div_d  = clr ? '0 : div_q + PRESC_W'(1);
		tick_d = !clr && ((div_q & mask) == mask);
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// [rtl/watchdog_interval_timer.sv]
// watchdog and interval timer with password-protected writes
`timescale 1ns/1ps
module watchdog_interval_timer (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        wr_stb,
	input  wire logic [15:0] wr_word,
	input  wire logic        status_rd_stb,
	input  wire logic        standby_recover,
	input  wire logic        nmi_pin_n,
	output logic      [7:0]  wdt_control_status_reg,
	output logic      [7:0]  wdt_count_reg,
	output logic             reset_source_bit,
	output logic             chip_reset_req,
	output logic             nmi_req,
	output logic             interval_overflow_request
);
	wdt_pkg::wdt_state_t                  state_q, state_d;
	logic [7:0]                           count_q, count_d;
	logic                                 ovf_q, ovf_d;
	logic                                 armed_q, armed_d;
	logic                                 mode_q, mode_d;
	logic                                 run_q, run_d;
	logic                                 act_q, act_d;
	logic [wdt_pkg::CKS_W-1:0]            cks_q, cks_d;
	logic                                 src_q, src_d;
	logic [wdt_pkg::RST_CNT_W-1:0]        rcnt_q, rcnt_d;
	logic                                 rreq_q, rreq_d;
	logic                                 nmi_q, nmi_d;
	logic                                 iovf_q, iovf_d;
	logic                                 pin_s1_q, pin_s2_q, pin_s3_q;
	logic                                 tick;
	logic                                 cnt_wr;
	logic                                 ctl_wr;
	logic                                 ovf_evt;

	localparam logic [wdt_pkg::RST_CNT_W-1:0] RST_LAST =
		wdt_pkg::RST_CNT_W'(wdt_pkg::RST_PULSE_CYCLES - 1);

	wdt_prescaler #(
		.PRESC_W (wdt_pkg::PRESC_W)
	) u_presc (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clr     (!run_q),
		.clk_sel (cks_q),
		.tick    (tick)
	);

	// one write address; the upper byte selects the target, anything else is dropped
	assign cnt_wr  = wr_stb && (wr_word[15:8] == wdt_pkg::PW_COUNT) && (state_q == wdt_pkg::ST_RUN);
	assign ctl_wr  = wr_stb && (wr_word[15:8] == wdt_pkg::PW_CTRL) && (state_q == wdt_pkg::ST_RUN);
	// a colliding counter write suppresses the increment, so it cannot overflow either
	// standby recovery clears the counter, so a same-cycle overflow is dropped with it
	assign ovf_evt = (state_q == wdt_pkg::ST_RUN) && run_q && tick && !cnt_wr && !standby_recover
		&& (count_q == wdt_pkg::COUNT_TOP);

	always_comb
	begin
		state_d = state_q;
		count_d = count_q;
		ovf_d   = ovf_q;
		armed_d = armed_q;
		mode_d  = mode_q;
		run_d   = run_q;
		act_d   = act_q;
		cks_d   = cks_q;
		src_d   = src_q;
		rcnt_d  = rcnt_q;
		rreq_d  = rreq_q;
		nmi_d   = 1'b0;
		iovf_d  = 1'b0;
		case (state_q)
			wdt_pkg::ST_RUN:
			begin
				if (standby_recover)
				begin
					// clock select and reset source bit survive standby, everything else returns to idle
					count_d = wdt_pkg::COUNT_RESET;
					ovf_d   = 1'b0;
					armed_d = 1'b0;
					mode_d  = 1'b0;
					run_d   = 1'b0;
					act_d   = 1'b0;
				end
				else
				begin
					if (!run_q)
						count_d = wdt_pkg::COUNT_RESET;
					else if (cnt_wr)
						count_d = wr_word[7:0];
					else if (tick)
						count_d = count_q + 8'h01;
					if (ctl_wr)
					begin
						mode_d = wr_word[wdt_pkg::MODE_BIT];
						run_d  = wr_word[wdt_pkg::RUN_BIT];
						act_d  = wr_word[wdt_pkg::ACT_BIT];
						cks_d  = wr_word[wdt_pkg::CKS_LSB +: wdt_pkg::CKS_W];
						// a zero write clears the flag only after it was read while set; writing one does nothing
						if (!wr_word[wdt_pkg::OVF_BIT] && armed_q)
						begin
							ovf_d   = 1'b0;
							armed_d = 1'b0;
						end
					end
					if (status_rd_stb && ovf_q)
						armed_d = 1'b1;
					// set beats a same-cycle clear so no overflow is lost
					if (ovf_evt)
						ovf_d = 1'b1;
					nmi_d  = ovf_evt && mode_q && !act_q;
					iovf_d = ovf_evt && !mode_q;
					if (ovf_evt && mode_q && act_q)
					begin
						// whole chip goes into reset, this block included
						state_d = wdt_pkg::ST_WDT_RESET;
						rcnt_d  = '0;
						rreq_d  = 1'b1;
						src_d   = 1'b0;
						count_d = wdt_pkg::COUNT_RESET;
						ovf_d   = 1'b0;
						armed_d = 1'b0;
						mode_d  = 1'b0;
						run_d   = 1'b0;
						act_d   = 1'b0;
						cks_d   = '0;
					end
				end
			end
			wdt_pkg::ST_WDT_RESET:
			begin
				rcnt_d = rcnt_q + wdt_pkg::RST_CNT_W'(1);
				if (rcnt_q == RST_LAST)
				begin
					// leave with defaults already in place
					state_d = wdt_pkg::ST_RUN;
					rreq_d  = 1'b0;
				end
			end
			default:
			begin
				state_d = wdt_pkg::ST_RUN;
				rreq_d  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_q <= wdt_pkg::ST_RUN;
			count_q <= wdt_pkg::COUNT_RESET;
			ovf_q   <= 1'b0;
			armed_q <= 1'b0;
			mode_q  <= 1'b0;
			run_q   <= 1'b0;
			act_q   <= 1'b0;
			cks_q   <= '0;
			src_q   <= 1'b1;
			rcnt_q  <= '0;
			rreq_q  <= 1'b0;
			nmi_q   <= 1'b0;
			iovf_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			count_q <= count_d;
			ovf_q   <= ovf_d;
			armed_q <= armed_d;
			mode_q  <= mode_d;
			run_q   <= run_d;
			act_q   <= act_d;
			cks_q   <= cks_d;
			src_q   <= src_d;
			rcnt_q  <= rcnt_d;
			rreq_q  <= rreq_d;
			nmi_q   <= nmi_d;
			iovf_q  <= iovf_d;
		end
	end

	// the pin is asynchronous; the second and third stages feed the edge detector
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_s3_q <= 1'b1;
		end
		else
		begin
			pin_s1_q <= nmi_pin_n;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	assign wdt_control_status_reg    = {ovf_q, mode_q, run_q, 1'b1, act_q, cks_q};
	assign wdt_count_reg             = count_q;
	assign reset_source_bit          = src_q;
	assign chip_reset_req            = rreq_q;
	// both sources land on the one NMI line and hence the same vector
	assign nmi_req                   = nmi_q || (pin_s3_q && !pin_s2_q);
	assign interval_overflow_request = iovf_q;

	// helper: length of the last reset pulse
	logic [wdt_pkg::RST_CNT_W-1:0] hi_cnt_q;
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !rreq_q)
			hi_cnt_q <= '0;
		else
			hi_cnt_q <= hi_cnt_q + wdt_pkg::RST_CNT_W'(1);
	end

	AST_RST_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(chip_reset_req) |-> int'(hi_cnt_q) == wdt_pkg::RST_PULSE_CYCLES)
		else $error("watchdog reset pulse length wrong");
	AST_RST_SEL: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf_evt && mode_q && act_q |=> chip_reset_req && !reset_source_bit && !nmi_q)
		else $error("reset action not taken");
	AST_NMI_SEL: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf_evt && mode_q && !act_q |=> nmi_req && !chip_reset_req)
		else $error("nmi action not taken");
	AST_INT: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf_evt && !mode_q |=> interval_overflow_request && !nmi_q && !chip_reset_req)
		else $error("interval request missing");
	AST_OVF_SET: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf_evt && !(mode_q && act_q) |=> wdt_control_status_reg[7])
		else $error("overflow flag not set");
	AST_STOP_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
		!run_q |=> wdt_count_reg == 8'h00)
		else $error("counter not held at zero while stopped");
	AST_WR_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
		cnt_wr && run_q && !standby_recover |=> wdt_count_reg == $past(wr_word[7:0]))
		else $error("counter write lost");
	AST_CKS_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
		standby_recover && state_q == wdt_pkg::ST_RUN
		|=> cks_q == $past(cks_q) && !run_q && !ovf_q && wdt_count_reg == 8'h00)
		else $error("standby recovery state wrong");
	AST_RELEASE: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(chip_reset_req) |-> wdt_control_status_reg == 8'h10 && wdt_count_reg == 8'h00)
		else $error("defaults not in place after watchdog reset");
	AST_NEED_RUN: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(chip_reset_req) |-> $past(mode_q) && $past(run_q))
		else $error("watchdog reset without watchdog mode");
endmodule

// [tb/cpu_event_model.sv]
// cpu side model: takes reset, nmi and interval requests and measures each chip reset
`timescale 1ns/1ps
module cpu_event_model (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic chip_reset_req,
	input  wire logic nmi_req,
	input  wire logic interval_overflow_request,
	output int        rst_len,
	output int        nmi_cnt,
	output int        ivl_cnt
);
	int run_len;

	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			run_len <= 0;
			rst_len <= 0;
			nmi_cnt <= 0;
			ivl_cnt <= 0;
		end
		else
		begin
			// chip reset is only timed here; unlike the external reset it clears no counts
			if (chip_reset_req === 1'b1)
				run_len <= run_len + 1;
			else if (run_len != 0)
			begin
				rst_len <= run_len;
				run_len <= 0;
			end
			// one nmi vector, whichever source raised it
			nmi_cnt <= nmi_cnt + int'(nmi_req === 1'b1);
			ivl_cnt <= ivl_cnt + int'(interval_overflow_request === 1'b1);
		end
	end
endmodule

// [tb/watchdog_interval_timer_tb_top.sv]
// self-checking bench for the watchdog and interval timer
`timescale 1ns/1ps
module watchdog_interval_timer_tb_top;
	logic        mclk, sys_rst, wr_stb, status_rd_stb, standby_recover, nmi_pin_n;
	logic [15:0] wr_word;
	logic [7:0]  ctrl, cnt;
	logic        rsrc, crst, nmi, ivl;
	int          rst_len, nmi_cnt, ivl_cnt, n_errors, checks, cyc;

	watchdog_interval_timer dut (.mclk(mclk), .sys_rst(sys_rst), .wr_stb(wr_stb), .wr_word(wr_word),
		.status_rd_stb(status_rd_stb), .standby_recover(standby_recover), .nmi_pin_n(nmi_pin_n),
		.wdt_control_status_reg(ctrl), .wdt_count_reg(cnt), .reset_source_bit(rsrc),
		.chip_reset_req(crst), .nmi_req(nmi), .interval_overflow_request(ivl));
	cpu_event_model cpu (.mclk(mclk), .sys_rst(sys_rst), .chip_reset_req(crst), .nmi_req(nmi),
		.interval_overflow_request(ivl), .rst_len(rst_len), .nmi_cnt(nmi_cnt), .ivl_cnt(ivl_cnt));

	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end

	// the slowest test needs about 17400 cycles
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 50000)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick;
		@(posedge mclk);
		#1;
	endtask

	// one word per strobe, released a full cycle later
	task automatic wr(input logic [15:0] w);
		tick();
		wr_stb = 1'b1;
		wr_word = w;
		tick();
		wr_stb = 1'b0;
	endtask

	// cpu read of the control/status register, arms the flag clear
	task automatic rd_stat;
		status_rd_stb = 1'b1;
		tick();
		status_rd_stb = 1'b0;
	endtask

	function automatic logic hit(input int s);
		case (s)
			0: return ivl === 1'b1;
			1: return nmi === 1'b1;
			2: return crst === 1'b1;
			default: return crst === 1'b0;
		endcase
	endfunction

	task automatic wait_ev(input int s, input int lim, output int n);
		n = 0;
		while (n < lim && !hit(s))
		begin
			tick();
			n++;
		end
		chk(16'(hit(s)), 16'h0001);
	endtask

	task automatic t_reset;
		chk(16'(ctrl), 16'h0010);
		chk(16'(cnt), 16'h0000);
		chk(16'(rsrc), 16'h0001);
		wr(16'h5A44);
		chk(16'(cnt), 16'h0000);
		wr(16'h3320);
		chk(16'(ctrl), 16'h0010);
		$display("test reset done");
	endtask

	task automatic t_interval;
		int n;
		wr(16'hA520);
		chk(16'(ctrl), 16'h0030);
		// back to back so this write lands between two count pulses
		wr(16'h5A10);
		chk(16'(cnt), 16'h0010);
		// one idle cycle puts the next write on an odd edge, where the count pulse lands
		tick();
		wr(16'h5A11);
		chk(16'(cnt), 16'h0011);
		wait_ev(0, 700, n);
		chk(16'(ctrl[7]), 16'h0001);
		chk(16'(nmi), 16'h0000);
		tick();
		wait_ev(0, 700, n);
		chk(16'(n + 1), 16'h0200);
		rd_stat();
		wr(16'hA5A0);
		chk(16'(ctrl), 16'h00B0);
		wr(16'hA520);
		chk(16'(ctrl), 16'h0030);
		wr(16'hA500);
		wr(16'hA521);
		wait_ev(0, 9000, n);
		tick();
		wait_ev(0, 9000, n);
		chk(16'(n + 1), 16'h2000);
		// the flag must be read while set before a zero write can clear it
		rd_stat();
		wr(16'hA500);
		chk(16'(ctrl), 16'h0010);
		chk(16'(ivl_cnt), 16'h0004);
		$display("test interval done");
	endtask

	task automatic t_watchdog;
		int n;
		wr(16'hA560);
		chk(16'(ctrl), 16'h0070);
		wr(16'h5AFF);
		wait_ev(1, 10, n);
		chk(16'(ctrl[7]), 16'h0001);
		chk(16'(crst), 16'h0000);
		wr(16'hA500);
		wr(16'hA568);
		// a stray word without a password must not switch the running watchdog from reset to nmi
		wr(16'h56F0);
		wr(16'h5AFF);
		wait_ev(2, 10, n);
		wr(16'hA520);
		chk(16'(ctrl), 16'h0010);
		wait_ev(3, 600, n);
		tick();
		chk(16'(rst_len), 16'h0206);
		chk(16'(ctrl), 16'h0010);
		chk(16'(cnt), 16'h0000);
		chk(16'(rsrc), 16'h0000);
		chk(16'(nmi_cnt), 16'h0001);
		$display("test watchdog done");
	endtask

	task automatic t_standby_pin;
		int n;
		wr(16'hA523);
		chk(16'(ctrl), 16'h0033);
		standby_recover = 1'b1;
		tick();
		standby_recover = 1'b0;
		chk(16'(ctrl), 16'h0013);
		chk(16'(cnt), 16'h0000);
		nmi_pin_n = 1'b0;
		wait_ev(1, 6, n);
		nmi_pin_n = 1'b1;
		tick();
		chk(16'(nmi), 16'h0000);
		chk(16'(nmi_cnt), 16'h0002);
		sys_rst = 1'b1;
		repeat (3) tick();
		sys_rst = 1'b0;
		chk(16'(rsrc), 16'h0001);
		chk(16'(ctrl), 16'h0010);
		$display("test standby and pin done");
	endtask

	initial
	begin
		sys_rst = 1'b1;
		wr_stb = 1'b0;
		wr_word = 16'h0000;
		status_rd_stb = 1'b0;
		standby_recover = 1'b0;
		nmi_pin_n = 1'b1;
		n_errors = 0;
		checks = 0;
		cyc = 0;
		repeat (10) tick();
		sys_rst = 1'b0;
		t_reset();
		t_interval();
		t_watchdog();
		t_standby_pin();
		complete_run();
	end
endmodule
